//--- rtl/psc_defines.svh
// Address map, field positions and reset values of the PHY statistics bank.
// Assumes a 32-bit AHB-Lite register port, one aligned word per register.
//
// Contract
// - CRC faults counted in 48 bits; low slice readable
// - Reading the high slice clears the whole counter
// - RXER rise with RXDV high counts; read clears
// - RXER rise with RXDV low counts; read clears
// - Every sent frame counted in 48 bits
// - Sent high read clears counter; others no effect
// - Sent high register holds bits 47 to 32
// - Sent mid holds bits 31 to 16; reset zero
// - Sent low register holds bits 15 to 0
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_ADDR_CRC_LOW   8'h00
`define PSC_ADDR_IN_FRAME  8'h04
`define PSC_ADDR_IN_IDLE   8'h08
`define PSC_ADDR_SENT_HIGH 8'h0c
`define PSC_ADDR_SENT_MID  8'h10
`define PSC_ADDR_SENT_LOW  8'h14
`define PSC_ADDR_CRC_MID   8'h18
`define PSC_ADDR_CRC_HIGH  8'h1c
`define PSC_ADDR_CTRL      8'h20

`define PSC_EN_CRC         0
`define PSC_EN_RXF         1
`define PSC_EN_SENT        2
`define PSC_CTRL_RESET     3'h7

`define PSC_CNT16_RESET    16'h0000
`define PSC_CNT48_RESET    48'h0000_0000_0000
`define PSC_SNAP_RESET     32'h0000_0000
`define PSC_ONE16          16'h0001
`define PSC_ONE48          48'h0000_0000_0001
`define PSC_WORD_ZERO      32'h0000_0000
`define PSC_ADDR_ZERO      8'h00
`define PSC_HRESP_OKAY     1'b0

`endif

//--- rtl/psc_pkg.sv
// Types shared by the statistics bank modules.
// Assumes psc_defines.svh supplies all numeric constants.
package psc_pkg;

  typedef struct packed {
    logic [47:0] count;
    logic [31:0] snap;
  } psc_tally_state_type;

  typedef struct packed {
    logic        rx_er_prev;
    logic [15:0] in_frame;
    logic [15:0] in_idle;
    logic [2:0]  enables;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        ready;
  } psc_top_state_type;

endpackage : psc_pkg

//--- rtl/psc_tally_if.sv
// Link between the register front end and one 48-bit tally.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface psc_tally_if;
  logic        inc;
  logic        rd_low;
  logic        rd_high;
  logic [47:0] live;
  logic [31:0] snap;

  modport ctl (output inc, output rd_low, output rd_high,
               input live, input snap);
  modport cnt (input inc, input rd_low, input rd_high,
               output live, output snap);
endinterface : psc_tally_if

//--- rtl/psc_tally48.sv
// One 48-bit event tally with clear-on-high-read and low-read snapshot.
// Assumes strobes are one-cycle pulses in the core_clk domain.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_tally48 (
  input wire logic core_clk, // 50 MHz core clock
  input wire logic sys_rst,  // Async reset, active high
  psc_tally_if.cnt t         // Strobes in, live value and snapshot out
);
  psc_pkg::psc_tally_state_type st_r;
  psc_pkg::psc_tally_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (t.rd_low) begin
      st_nxt.snap = st_r.count[47:16];
    end
    if (t.rd_high) begin
      st_nxt.count = `PSC_CNT48_RESET;
    end
    // Increment after the clear so a coincident event is not lost
    if (t.inc) begin
      st_nxt.count = st_nxt.count + `PSC_ONE48;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.count <= `PSC_CNT48_RESET;
      st_r.snap  <= `PSC_SNAP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign t.live = st_r.count;
  assign t.snap = st_r.snap;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  high_read_clear_a: assert property (
    t.rd_high && !t.inc |=> t.live == `PSC_CNT48_RESET)
    else $error("counter not cleared by high read");
  count_step_a: assert property (
    t.inc && !t.rd_high |=> t.live == $past(t.live) + `PSC_ONE48)
    else $error("counter did not step by one");
  low_snapshot_a: assert property (
    t.rd_low |=> t.snap == $past(t.live[47:16]))
    else $error("snapshot does not match counter");
  count_wrap_a: assert property (
    t.inc && !t.rd_high && (&t.live) |=> t.live == `PSC_CNT48_RESET)
    else $error("counter did not wrap");
endmodule : psc_tally48

//--- rtl/psc_stats_bank.sv
// Statistics counter bank of the PHY behind an AHB-Lite slave port.
// Assumes event inputs are synchronous to core_clk and one master on
// the bus; every access completes with zero wait states.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_stats_bank (
  input  wire logic        core_clk,   // 50 MHz core clock
  input  wire logic        sys_rst,    // Async reset, active high
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Transfer size, word only
  input  wire logic        hready,     // Bus ready
  input  wire logic [31:0] hwdata,     // Write data
  output logic      [31:0] hrdata,     // Read data
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Response, always OKAY
  input  wire logic        crc_fault,  // CRC checker error pulse
  input  wire logic        rx_er,      // Receive error level
  input  wire logic        rx_dv,      // Receive data valid level
  input  wire logic        frame_sent  // One pulse per sent frame
);
  psc_pkg::psc_top_state_type st_r;
  psc_pkg::psc_top_state_type st_nxt;

  psc_tally_if crc_t ();
  psc_tally_if sent_t ();

  psc_tally48 u_crc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .t        (crc_t.cnt)
  );

  psc_tally48 u_sent (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .t        (sent_t.cnt)
  );

  // Only addresses inside the first 256 bytes are mapped
  function automatic logic in_map(input logic [31:0] a);
    in_map = (a[31:8] == 24'h00_0000);
  endfunction : in_map

  function automatic logic is_reg(input logic [31:0] a,
                                  input logic [7:0]  off);
    is_reg = in_map(a) && (a[7:0] == off);
  endfunction : is_reg

  logic        acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        er_rise;
  logic        rd_in_frame;
  logic        rd_in_idle;
  logic [31:0] rd_word;

  // hsize is not checked: only whole-word transfers are issued
  assign acc    = hsel && htrans[1] && hready;
  assign rd_acc = acc && !hwrite;
  assign wr_acc = acc && hwrite;

  assign er_rise     = rx_er && !st_r.rx_er_prev;
  assign rd_in_frame = rd_acc && is_reg(haddr, `PSC_ADDR_IN_FRAME);
  assign rd_in_idle  = rd_acc && is_reg(haddr, `PSC_ADDR_IN_IDLE);

  assign crc_t.inc     = crc_fault && st_r.enables[`PSC_EN_CRC];
  assign crc_t.rd_low  = rd_acc && is_reg(haddr, `PSC_ADDR_CRC_LOW);
  assign crc_t.rd_high = rd_acc && is_reg(haddr, `PSC_ADDR_CRC_HIGH);
  assign sent_t.inc    = frame_sent && st_r.enables[`PSC_EN_SENT];
  assign sent_t.rd_low = rd_acc && is_reg(haddr, `PSC_ADDR_SENT_LOW);
  assign sent_t.rd_high = rd_acc && is_reg(haddr, `PSC_ADDR_SENT_HIGH);

  // Read data mux, sampled at the address phase so side effects and
  // returned value refer to the same instant
  always_comb begin
    rd_word = `PSC_WORD_ZERO;
    if (in_map(haddr)) begin
      case (haddr[7:0])
        `PSC_ADDR_CRC_LOW: begin
          rd_word[15:0] = crc_t.live[15:0];
        end
        `PSC_ADDR_CRC_MID: begin
          rd_word[15:0] = crc_t.snap[15:0];
        end
        `PSC_ADDR_CRC_HIGH: begin
          rd_word[15:0] = crc_t.snap[31:16];
        end
        `PSC_ADDR_IN_FRAME: begin
          rd_word[15:0] = st_r.in_frame;
        end
        `PSC_ADDR_IN_IDLE: begin
          rd_word[15:0] = st_r.in_idle;
        end
        `PSC_ADDR_SENT_HIGH: begin
          rd_word[15:0] = sent_t.snap[31:16];
        end
        `PSC_ADDR_SENT_MID: begin
          rd_word[15:0] = sent_t.snap[15:0];
        end
        `PSC_ADDR_SENT_LOW: begin
          rd_word[15:0] = sent_t.live[15:0];
        end
        `PSC_ADDR_CTRL: begin
          rd_word[2:0] = st_r.enables;
        end
        default: begin
          rd_word = `PSC_WORD_ZERO;
        end
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_er_prev = rx_er;
    st_nxt.ready = 1'b1;
    st_nxt.rdata = rd_acc ? rd_word : `PSC_WORD_ZERO;

    // Read clears first, then a coincident edge counts as one
    if (rd_in_frame) begin
      st_nxt.in_frame = `PSC_CNT16_RESET;
    end
    if (rd_in_idle) begin
      st_nxt.in_idle = `PSC_CNT16_RESET;
    end
    if (er_rise && st_r.enables[`PSC_EN_RXF]) begin
      if (rx_dv) begin
        st_nxt.in_frame = st_nxt.in_frame + `PSC_ONE16;
      end else begin
        st_nxt.in_idle = st_nxt.in_idle + `PSC_ONE16;
      end
    end

    // Data phase of a write; counters themselves ignore writes
    if (st_r.wr_pend && st_r.wr_addr == `PSC_ADDR_CTRL) begin
      st_nxt.enables = hwdata[2:0];
    end
    st_nxt.wr_pend = wr_acc;
    st_nxt.wr_addr = (wr_acc && in_map(haddr)) ? haddr[7:0]
                                               : `PSC_ADDR_ZERO;
    if (wr_acc && !in_map(haddr)) begin
      st_nxt.wr_pend = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.rx_er_prev <= 1'b0;
      st_r.in_frame   <= `PSC_CNT16_RESET;
      st_r.in_idle    <= `PSC_CNT16_RESET;
      st_r.enables    <= `PSC_CTRL_RESET;
      st_r.wr_pend    <= 1'b0;
      st_r.wr_addr    <= `PSC_ADDR_ZERO;
      st_r.rdata      <= `PSC_WORD_ZERO;
      st_r.ready      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata    = st_r.rdata;
  assign hreadyout = st_r.ready;
  assign hresp     = `PSC_HRESP_OKAY;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence frame_edge_s;
    rx_er && !st_r.rx_er_prev && rx_dv && st_r.enables[`PSC_EN_RXF];
  endsequence
  sequence idle_edge_s;
    rx_er && !st_r.rx_er_prev && !rx_dv && st_r.enables[`PSC_EN_RXF];
  endsequence
  sequence read_of_s(logic [7:0] off);
    rd_acc && is_reg(haddr, off);
  endsequence
  // Ordered slice reads from a single-transfer master: an idle bus
  // cycle between address phases, so no second low read re-snapshots
  sequence crc_low_mid_s;
    read_of_s(`PSC_ADDR_CRC_LOW) ##1 !rd_acc ##1
      read_of_s(`PSC_ADDR_CRC_MID);
  endsequence
  sequence sent_low_mid_s;
    read_of_s(`PSC_ADDR_SENT_LOW) ##1 !rd_acc ##1
      read_of_s(`PSC_ADDR_SENT_MID);
  endsequence

  frame_err_count_a: assert property (
    frame_edge_s and !rd_in_frame |=>
      st_r.in_frame == $past(st_r.in_frame) + `PSC_ONE16)
    else $error("in-frame count did not step");
  idle_err_count_a: assert property (
    idle_edge_s and !rd_in_idle |=>
      st_r.in_idle == $past(st_r.in_idle) + `PSC_ONE16)
    else $error("idle count did not step");
  frame_read_clear_a: assert property (
    read_of_s(`PSC_ADDR_IN_FRAME) and !er_rise |=>
      st_r.in_frame == `PSC_CNT16_RESET &&
      hrdata[15:0] == $past(st_r.in_frame))
    else $error("in-frame read did not return then clear");
  idle_read_clear_a: assert property (
    read_of_s(`PSC_ADDR_IN_IDLE) and !er_rise |=>
      st_r.in_idle == `PSC_CNT16_RESET)
    else $error("idle read did not clear");
  crc_low_data_a: assert property (
    read_of_s(`PSC_ADDR_CRC_LOW) |=>
      hrdata == {16'h0000, $past(crc_t.live[15:0])})
    else $error("crc low read data wrong");
  sent_low_data_a: assert property (
    read_of_s(`PSC_ADDR_SENT_LOW) |=>
      hrdata[15:0] == $past(sent_t.live[15:0]))
    else $error("sent low read data wrong");
  sent_mid_data_a: assert property (
    sent_low_mid_s |=>
      hrdata[15:0] == $past(sent_t.live[31:16], 3))
    else $error("sent mid read data wrong");
  sent_high_clear_a: assert property (
    read_of_s(`PSC_ADDR_SENT_HIGH) and !sent_t.inc |=>
      sent_t.live == `PSC_CNT48_RESET &&
      hrdata[15:0] == $past(sent_t.snap[31:16]))
    else $error("sent high read did not clear");
  crc_high_clear_a: assert property (
    read_of_s(`PSC_ADDR_CRC_HIGH) and !crc_t.inc |=>
      crc_t.live == `PSC_CNT48_RESET)
    else $error("crc high read did not clear");
  zero_wait_a: assert property (
    acc |=> hreadyout && hresp == `PSC_HRESP_OKAY)
    else $error("slave inserted a wait or error");

  // Slice data: mid and high must show the counter as it stood at the
  // low read, however many events arrived in between
  crc_mid_data_a: assert property (
    crc_low_mid_s |=>
      hrdata == {16'h0000, $past(crc_t.live[31:16], 3)})
    else $error("crc mid read data wrong");

  crc_high_data_a: assert property (
    crc_low_mid_s ##1 !rd_acc ##1 read_of_s(`PSC_ADDR_CRC_HIGH) |=>
      hrdata == {16'h0000, $past(crc_t.live[47:32], 5)})
    else $error("crc high read data wrong");

  sent_high_data_a: assert property (
    sent_low_mid_s ##1 !rd_acc ##1 read_of_s(`PSC_ADDR_SENT_HIGH) |=>
      hrdata == {16'h0000, $past(sent_t.live[47:32], 5)})
    else $error("sent high read data wrong");

  idle_read_data_a: assert property (
    read_of_s(`PSC_ADDR_IN_IDLE) |=>
      hrdata == {16'h0000, $past(st_r.in_idle)})
    else $error("idle read data wrong");

  upper_half_zero_a: assert property (
    rd_acc |=> hrdata[31:16] == 16'h0000)
    else $error("read data above bit 15 not zero");

  rdata_rest_a: assert property (
    !rd_acc |=> hrdata == `PSC_WORD_ZERO)
    else $error("read data left standing");

  unmapped_zero_a: assert property (
    rd_acc && (!in_map(haddr) || haddr[7:0] > `PSC_ADDR_CTRL) |=>
      hrdata == `PSC_WORD_ZERO)
    else $error("unmapped read not zero");

  // Control register: written in the data phase, otherwise held
  ctrl_read_a: assert property (
    read_of_s(`PSC_ADDR_CTRL) |=>
      hrdata == {29'h0000_0000, $past(st_r.enables)})
    else $error("control read data wrong");

  ctrl_write_a: assert property (
    st_r.wr_pend && st_r.wr_addr == `PSC_ADDR_CTRL |=>
      st_r.enables == $past(hwdata[2:0]))
    else $error("control write not taken");

  ctrl_hold_a: assert property (
    !(st_r.wr_pend && st_r.wr_addr == `PSC_ADDR_CTRL) |=>
      st_r.enables == $past(st_r.enables))
    else $error("control changed without a write");

  // Receive error tallies move only on an edge or a read
  edge_track_a: assert property (
    1'b1 |=> st_r.rx_er_prev == $past(rx_er))
    else $error("edge detector lost rx_er");

  frame_hold_a: assert property (
    !er_rise && !rd_in_frame |=>
      st_r.in_frame == $past(st_r.in_frame))
    else $error("in-frame count moved without cause");

  idle_hold_a: assert property (
    !er_rise && !rd_in_idle |=>
      st_r.in_idle == $past(st_r.in_idle))
    else $error("idle count moved without cause");

  rx_off_a: assert property (
    er_rise && !st_r.enables[`PSC_EN_RXF] && !rd_in_frame &&
      !rd_in_idle |=>
      st_r.in_frame == $past(st_r.in_frame) &&
      st_r.in_idle == $past(st_r.in_idle))
    else $error("disabled receive error counted");

  // 48-bit tallies seen from the pins
  crc_step_a: assert property (
    crc_fault && st_r.enables[`PSC_EN_CRC] && !crc_t.rd_high |=>
      crc_t.live == $past(crc_t.live) + `PSC_ONE48)
    else $error("crc fault not counted");

  sent_step_a: assert property (
    frame_sent && st_r.enables[`PSC_EN_SENT] && !sent_t.rd_high |=>
      sent_t.live == $past(sent_t.live) + `PSC_ONE48)
    else $error("sent frame not counted");

  crc_off_a: assert property (
    crc_fault && !st_r.enables[`PSC_EN_CRC] && !crc_t.rd_high |=>
      crc_t.live == $past(crc_t.live))
    else $error("disabled crc fault counted");

  sent_off_a: assert property (
    frame_sent && !st_r.enables[`PSC_EN_SENT] && !sent_t.rd_high |=>
      sent_t.live == $past(sent_t.live))
    else $error("disabled sent frame counted");

  crc_idle_hold_a: assert property (
    !crc_fault && !crc_t.rd_high |=>
      crc_t.live == $past(crc_t.live))
    else $error("crc count moved without cause");

  sent_idle_hold_a: assert property (
    !frame_sent && !sent_t.rd_high |=>
      sent_t.live == $past(sent_t.live))
    else $error("sent count moved by a low or mid read");

  sent_snap_hold_a: assert property (
    !sent_t.rd_low |=> sent_t.snap == $past(sent_t.snap))
    else $error("sent snapshot moved without a low read");

  crc_snap_hold_a: assert property (
    !crc_t.rd_low |=> crc_t.snap == $past(crc_t.snap))
    else $error("crc snapshot moved without a low read");
endmodule : psc_stats_bank

//--- testbench/tb_psc_stats_bank.sv
// Self-checking bench for the PHY statistics counter bank.
// Assumes a single AHB-Lite master, with hready taken from hreadyout.
`timescale 1ns/1ps
`include "psc_defines.svh"
module tb_psc_stats_bank;
  logic        core_clk;   // Core clock
  logic        sys_rst;    // Async reset
  logic        hsel;       // Slave select
  logic [31:0] haddr;      // Byte address
  logic [1:0]  htrans;     // Transfer type
  logic        hwrite;     // Write flag
  logic [2:0]  hsize;      // Transfer size
  wire         hready;     // Bus ready
  logic [31:0] hwdata;     // Write data
  logic [31:0] hrdata;     // Read data
  logic        hreadyout;  // Slave ready
  logic        hresp;      // Response
  logic        crc_fault;  // CRC error pulse
  logic        rx_er;      // Receive error level
  logic        rx_dv;      // Receive valid level
  logic        frame_sent; // Sent frame pulse
  int          mismatches;
  int          compares;

  assign hready = hreadyout;

  psc_stats_bank dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .crc_fault(crc_fault), .rx_er(rx_er), .rx_dv(rx_dv),
    .frame_sent(frame_sent)
  );

  always #10 core_clk = ~core_clk;

  task automatic test_done;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Returns in the time step of the rising edge at which hready was
  // sampled high; the slave only moves hready after that edge.
  task automatic wait_ready;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (hready === 1'b1) break;
    end
    if (i == 50) begin
      mismatches++;
      test_done();
    end
  endtask : wait_ready

  // Address phase held until hready, then data phase until hready;
  // read data taken at the edge that ends the data phase.
  task automatic bus(input logic [7:0] addr, input logic wr,
                     input logic [31:0] wdata, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rd = hrdata;
    check("response", {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic rd_chk(input string what, input logic [7:0] addr,
                        input logic [31:0] exp);
    logic [31:0] v;
    bus(addr, 1'b0, 32'h0000_0000, v);
    check(what, v, exp);
  endtask : rd_chk

  // Pulses the chosen event inputs high for n consecutive edges
  task automatic events(input int n, input logic c, input logic f);
    crc_fault  <= c;
    frame_sent <= f;
    repeat (n) @(posedge core_clk);
    crc_fault  <= 1'b0;
    frame_sent <= 1'b0;
    @(posedge core_clk);
  endtask : events

  // One rising edge of rx_er, held two cycles so it must count once
  task automatic rx_edge(input logic dv);
    rx_dv <= dv;
    rx_er <= 1'b1;
    repeat (2) @(posedge core_clk);
    rx_er <= 1'b0;
    @(posedge core_clk);
  endtask : rx_edge

  task automatic reset_values;
    rd_chk("crc low", `PSC_ADDR_CRC_LOW, 32'h0000_0000);
    rd_chk("in frame", `PSC_ADDR_IN_FRAME, 32'h0000_0000);
    rd_chk("in idle", `PSC_ADDR_IN_IDLE, 32'h0000_0000);
    rd_chk("sent high", `PSC_ADDR_SENT_HIGH, 32'h0000_0000);
    rd_chk("sent mid", `PSC_ADDR_SENT_MID, 32'h0000_0000);
    rd_chk("sent low", `PSC_ADDR_SENT_LOW, 32'h0000_0000);
    rd_chk("ctrl", `PSC_ADDR_CTRL, 32'h0000_0007);
  endtask : reset_values

  task automatic sent_tally;
    events(5, 1'b0, 1'b1);
    rd_chk("sent low", `PSC_ADDR_SENT_LOW, 32'h0000_0005);
    events(2, 1'b0, 1'b1);
    rd_chk("sent mid", `PSC_ADDR_SENT_MID, 32'h0000_0000);
    rd_chk("sent mid again", `PSC_ADDR_SENT_MID, 32'h0000_0000);
    rd_chk("sent low kept", `PSC_ADDR_SENT_LOW, 32'h0000_0007);
    rd_chk("sent high", `PSC_ADDR_SENT_HIGH, 32'h0000_0000);
    rd_chk("sent low clr", `PSC_ADDR_SENT_LOW, 32'h0000_0000);
  endtask : sent_tally

  // Enough frames to carry into the mid slice, read in order
  task automatic sent_wide;
    events(65537, 1'b0, 1'b1);
    rd_chk("wide low", `PSC_ADDR_SENT_LOW, 32'h0000_0001);
    rd_chk("wide mid", `PSC_ADDR_SENT_MID, 32'h0000_0001);
    rd_chk("wide high", `PSC_ADDR_SENT_HIGH, 32'h0000_0000);
    rd_chk("wide clr", `PSC_ADDR_SENT_LOW, 32'h0000_0000);
  endtask : sent_wide

  task automatic crc_tally;
    events(3, 1'b1, 1'b0);
    rd_chk("crc low", `PSC_ADDR_CRC_LOW, 32'h0000_0003);
    rd_chk("crc mid", `PSC_ADDR_CRC_MID, 32'h0000_0000);
    rd_chk("crc high", `PSC_ADDR_CRC_HIGH, 32'h0000_0000);
    rd_chk("crc low clr", `PSC_ADDR_CRC_LOW, 32'h0000_0000);
  endtask : crc_tally

  task automatic rx_tally;
    rx_edge(1'b1);
    rx_edge(1'b1);
    rx_edge(1'b0);
    rx_edge(1'b0);
    rx_edge(1'b0);
    rd_chk("in frame", `PSC_ADDR_IN_FRAME, 32'h0000_0002);
    rd_chk("in idle", `PSC_ADDR_IN_IDLE, 32'h0000_0003);
    rd_chk("in frame clr", `PSC_ADDR_IN_FRAME, 32'h0000_0000);
    rd_chk("in idle clr", `PSC_ADDR_IN_IDLE, 32'h0000_0000);
  endtask : rx_tally

  // Disabled categories must ignore events; unmapped space reads zero
  task automatic ctrl_and_unmapped;
    logic [31:0] v;
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h0000_0000, v);
    rd_chk("ctrl off", `PSC_ADDR_CTRL, 32'h0000_0000);
    events(2, 1'b1, 1'b1);
    rx_edge(1'b1);
    rd_chk("crc off", `PSC_ADDR_CRC_LOW, 32'h0000_0000);
    rd_chk("sent off", `PSC_ADDR_SENT_LOW, 32'h0000_0000);
    rd_chk("frame off", `PSC_ADDR_IN_FRAME, 32'h0000_0000);
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h0000_0007, v);
    bus(8'h40, 1'b1, 32'h1234_5678, v);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    bus(`PSC_ADDR_SENT_LOW, 1'b1, 32'h0000_00aa, v);
    rd_chk("ro write", `PSC_ADDR_SENT_LOW, 32'h0000_0000);
    events(1, 1'b1, 1'b1);
    rd_chk("crc on", `PSC_ADDR_CRC_LOW, 32'h0000_0001);
  endtask : ctrl_and_unmapped

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    crc_fault = 1'b0;
    rx_er = 1'b0;
    rx_dv = 1'b0;
    frame_sent = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    reset_values();
    sent_tally();
    sent_wide();
    crc_tally();
    rx_tally();
    ctrl_and_unmapped();
    test_done();
  end
endmodule : tb_psc_stats_bank
